// *** common/vcs_pkg.sv ***
// Constants and carriers for the capture channel status bank.
// Assumes a 32-bit classic Wishbone register bus and one clock.
`default_nettype none
package vcs_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STAT_A = 8'h00; // Channel A status
  localparam logic [7:0] OFS_STAT_B = 8'h04; // Channel B status
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08; // Port irq status, read clears
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c; // Port irq mask
  localparam logic [7:0] OFS_CFG_A = 8'h10; // Channel A mode and selects
  localparam logic [7:0] OFS_CFG_B = 8'h14; // Channel B mode and selects
  localparam logic [7:0] OFS_VINT_A = 8'h18; // Channel A vertical int lines
  localparam logic [7:0] OFS_VINT_B = 8'h1c; // Channel B vertical int lines
  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int BIT_SYNC = 31;
  localparam int BIT_FRAME = 30;
  localparam int BIT_F2 = 29;
  localparam int BIT_F1 = 28;
  localparam int BIT_FIELD = 12;
  localparam int POS_W = 12; // Width of each position field
  localparam int VINT_TWO_LSB = 16; // Line two sits in the vint upper half
  localparam logic [11:0] SYNC_SET_LINE = 12'h001; // Line that raises sync
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  // Capture modes
  typedef enum logic [1:0] {
    MODE_COMP = 2'b00,
    MODE_RAW = 2'b01,
    MODE_TS = 2'b10
  } vcs_mode_t;
  // Per-channel configuration
  typedef struct packed {
    logic sync_line_select;
    logic field_detect_select;
    logic [1:0] mode;
  } vcs_cfg_t;
  // Per-channel inputs from the capture datapath, same clock
  typedef struct packed {
    logic [11:0] pixel_counter;
    logic [11:0] line_counter;
    logic [23:0] sample_count;
    logic field_one_end;
    logic field_two_end;
    logic frame_end;
    logic fid_code;
    logic fid_sync;
  } vcs_cap_t;
endpackage
`default_nettype wire

// *** verif/tb_video_capture_channel_status.sv ***
// Bench for the capture status bank: Wishbone tasks, one task per scenario.
// Assumes the package, the design and the capture model are compiled first.
`default_nettype none
module tb_video_capture_channel_status;
  import vcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  int fail_count = 0;
  int n_checks = 0;
  logic clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dato, q;
  wire vcs_cap_t [1:0] cap; // One record per channel, each from its own model
  logic [11:0] pix [2];
  logic [11:0] ln [2];
  logic [23:0] cnt [2];
  logic [1:0] fid [2];
  logic [2:0] ev [2];
  vcs_status u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato),
    .wb_ack_o(ack), .cap_i(cap), .irq_o(irq));
  for (genvar c = 0; c < 2; c++) begin : g_cap
    vcs_cap_model u_cap (.clk_i(clk_i), .rst_i(rst_i), .pix_i(pix[c]), .line_i(ln[c]),
      .cnt_i(cnt[c]), .fid_i(fid[c]), .ev_i(ev[c]), .cap_o(cap[c]));
  end
  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    // No limit here: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    `CHK("ack wait", 2, n)
  endtask
  task automatic rdst(input int c);
    wb(1'b0, c ? OFS_STAT_B : OFS_STAT_A, 4'hf, 32'h0);
  endtask
  task automatic setc(input int c, input logic [11:0] l, input logic [23:0] n,
      input logic [1:0] f);
    @(posedge clk_i);
    pix[c] <= 12'h123;
    ln[c] <= l;
    cnt[c] <= n;
    fid[c] <= f;
    repeat (3) @(posedge clk_i);
  endtask
  // Events are one-cycle pulses; the wait covers flag and irq latency
  task automatic pulse(input int c, input logic [2:0] e);
    @(posedge clk_i);
    ev[c] <= e;
    @(posedge clk_i);
    ev[c] <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pos(input int c);
    rdst(c);
    `CHK("reset status", STAT_RESET, q)
    wb(1'b1, c ? OFS_CFG_B : OFS_CFG_A, 4'hf, 32'h0);
    setc(c, 12'h005, 24'hffffff, 2'b10);
    rdst(c);
    `CHK("position", 32'h0005_1123, q)
    wb(1'b1, c ? OFS_CFG_B : OFS_CFG_A, 4'hf, 32'h4);
    rdst(c);
    `CHK("field by sync", 1'b0, q[BIT_FIELD])
  endtask
  task automatic t_raw(input int c, input logic [1:0] m);
    wb(1'b1, c ? OFS_CFG_B : OFS_CFG_A, 4'hf, {30'h0, m});
    setc(c, 12'h001, 24'habcdef, {2{m[0]}}); // Field 2 or line 1 of field 1
    pulse(c, 3'b111);
    rdst(c);
    `CHK("raw status", 32'h4abc_0def, q)
    wb(1'b1, c ? OFS_STAT_B : OFS_STAT_A, 4'hf, 32'h4000_0000);
    rdst(c);
    `CHK("raw cleared", 32'h0abc_0def, q)
  endtask
  task automatic t_flag(input int c);
    wb(1'b1, c ? OFS_CFG_B : OFS_CFG_A, 4'hf, 32'h0);
    wb(1'b1, OFS_IRQ_MASK, 4'hf, 32'h1 << c);
    wb(1'b0, OFS_IRQ_STAT, 4'hf, 32'h0); // Drop completions left by earlier tests
    setc(c, 12'h020, 24'h0, 2'b00);
    `CHK("irq idle", 1'b0, irq)
    pulse(c, 3'b111);
    `CHK("irq raised", 1'b1, irq)
    wb(1'b1, c ? OFS_STAT_B : OFS_STAT_A, 4'h7, 32'hffff_ffff);
    wb(1'b1, c ? OFS_STAT_B : OFS_STAT_A, 4'hf, 32'h0000_e000);
    wb(1'b1, c ? OFS_STAT_B : OFS_STAT_A, 4'hf, 32'h1000_0000);
    rdst(c);
    `CHK("one flag cleared", 32'h6020_0123, q)
    wb(1'b0, OFS_IRQ_STAT, 4'hf, 32'h0);
    `CHK("irq status", 1'b1, q[c])
    repeat (2) @(posedge clk_i);
    `CHK("irq after read", 1'b0, irq)
    wb(1'b1, c ? OFS_STAT_B : OFS_STAT_A, 4'hf, 32'h6000_0000);
    wb(1'b1, OFS_IRQ_MASK, 4'hf, 32'h0);
    pulse(c, 3'b001);
    `CHK("masked irq", 1'b0, irq)
    wb(1'b0, 8'h40, 4'hf, 32'h0);
    `CHK("unmapped read", 32'h0, q)
  endtask
  // Line one is 7, line two is 9; the select picks which one ends sync
  task automatic t_sync(input int c);
    logic [11:0] miss;
    wb(1'b1, c ? OFS_VINT_B : OFS_VINT_A, 4'hf, 32'h0009_0007);
    wb(1'b0, c ? OFS_VINT_B : OFS_VINT_A, 4'hf, 32'h0);
    `CHK("vint readback", 32'h0009_0007, q)
    for (int s = 0; s < 2; s++) begin
      miss = s ? 12'h007 : 12'h009;
      wb(1'b1, c ? OFS_CFG_B : OFS_CFG_A, 4'hf, s << 3);
      setc(c, 12'h001, 24'h0, 2'b00);
      rdst(c);
      `CHK("sync set", 1'b1, q[BIT_SYNC])
      setc(c, miss, 24'h0, 2'b00);
      rdst(c);
      `CHK("sync kept", 1'b1, q[BIT_SYNC])
      setc(c, s ? 12'h009 : 12'h007, 24'h0, 2'b00);
      rdst(c);
      `CHK("sync cleared", 1'b0, q[BIT_SYNC])
    end
    setc(c, 12'h001, 24'h0, 2'b10);
    rdst(c);
    `CHK("no sync in field two", 1'b0, q[BIT_SYNC])
  endtask
  // Reset in mid-run drops pending flags and the irq; positions follow inputs
  task automatic t_reset();
    setc(0, 12'h000, 24'h0, 2'b00);
    wb(1'b1, OFS_IRQ_MASK, 4'hf, 32'h1);
    pulse(0, 3'b111);
    `CHK("irq before reset", 1'b1, irq)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdst(0);
    `CHK("flags after reset", 4'h0, q[31:28])
    `CHK("irq after reset", 1'b0, irq)
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // The whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, dat} = '0;
    foreach (pix[c]) begin
      {pix[c], ln[c], cnt[c], fid[c], ev[c]} = '0;
    end
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      t_pos(c);
      t_raw(c, 2'b01);
      t_raw(c, 2'b10);
      t_raw(c, 2'b11);
      t_flag(c);
      t_sync(c);
    end
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire

// *** verif/vcs_cap_model.sv ***
// Capture datapath model for one channel of the status bank.
// Assumes the bench changes its requests right after a rising edge of clk_i.
`default_nettype none
module vcs_cap_model
  import vcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requested positions, field ids {code, sync} and events {f1, f2, frame}
  input wire logic [11:0] pix_i,
  input wire logic [11:0] line_i,
  input wire logic [23:0] cnt_i,
  input wire logic [1:0] fid_i,
  input wire logic [2:0] ev_i,
  // Record seen by the bank
  output var vcs_cap_t cap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One register stage like the real datapath; events last one cycle only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_o <= '0;
    end else begin
      cap_o <= {pix_i, line_i, cnt_i, ev_i, fid_i};
    end
  end
endmodule
`default_nettype wire

// *** verilog/vcs_status.sv ***
// Status register bank of a two-channel video capture port.
// Assumes the capture datapath runs on clk_i and gives one-cycle end pulses.
`default_nettype none
// Notes on behaviour
// - Component modes: line counter in bits 27:16
// - Component modes: pixel counter in bits 11:0
// - Raw/stream modes: 24-bit sample count split
// - Frame, block or packet done sets bit 30
// - Component modes: field done sets 29, 28
// - Completion flags: write one clears, zero keeps
// - Sync flag clears at selected vertical line
// - Sync flag sets at line 1, field 1
// - Active field bit 12 per detect select
// - Bits 15:13 read zero, ignore writes
// - Two channels, identical status layout
// - Frame done also sets port irq bit
module vcs_status
  import vcs_pkg::*;
#(
  parameter int N_CH = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Capture datapath, one record per channel
  input wire vcs_cap_t [1:0] cap_i,
  // Interrupt
  output logic irq_o
);
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  // The map holds exactly two channels
  if (N_CH != 2) begin : g_bad_ch
    $error("vcs_status supports two channels only");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  vcs_cfg_t cfg [2]; // Mode and selects
  logic [31:0] vint [2]; // Vertical int lines one and two
  logic [1:0] sync_f; // Frame sync flags
  logic [1:0] frame_f; // Frame complete flags
  logic [1:0] f2_f; // Field two done flags
  logic [1:0] f1_f; // Field one done flags
  logic [1:0] fld; // Active field bits
  logic [23:0] pos [2]; // Position or sample count
  logic [1:0] irq_st; // Capture complete irq status
  logic [1:0] irq_mask; // Irq mask, same layout
  logic [31:0] next_rdata; // Read mux
  logic acc; // Request taken this edge
  logic [1:0] wr_stat; // Write hits a status register
  logic [1:0] comp; // Channel in component mode
  logic [1:0] fld_now; // Field indication feeding the flag
  logic [1:0] sync_set; // Sync set condition
  logic [1:0] sync_clr; // Sync clear condition

  // Packs one channel's status word
  function automatic logic [31:0] stat_word(input logic s, input logic fr,
      input logic f2, input logic f1, input logic fl, input logic [23:0] p);
    return {s, fr, f2, f1, p[23:12], 3'b000, fl, p[11:0]};
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Single wait state: the access completes on the edge raising ack
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes and clears land on the taking edge, so they are in place by ack
  assign wr_stat[0] = acc & wb_we_i & wb_sel_i[3] & (wb_adr_i == OFS_STAT_A);
  assign wr_stat[1] = acc & wb_we_i & wb_sel_i[3] & (wb_adr_i == OFS_STAT_B);

  // Per-channel combinational conditions
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      comp[c] = (cfg[c].mode == MODE_COMP);
      // Detect select picks the embedded code or the sync-based guess
      fld_now[c] = cfg[c].field_detect_select ? cap_i[c].fid_sync
                                              : cap_i[c].fid_code;
      sync_set[c] = comp[c] & ~fld_now[c]
                    & (cap_i[c].line_counter == SYNC_SET_LINE);
      sync_clr[c] = comp[c] & (cap_i[c].line_counter ==
          (cfg[c].sync_line_select ? vint[c][VINT_TWO_LSB +: POS_W]
                                   : vint[c][POS_W-1:0]));
    end
  end

  // Read data mux; unmapped offsets read zero
  // Data is taken at the taking edge, before any clear of that same edge
  always_comb begin
    unique case (wb_adr_i)
      OFS_STAT_A: next_rdata = stat_word(sync_f[0], frame_f[0], f2_f[0],
                                         f1_f[0], fld[0], pos[0]);
      OFS_STAT_B: next_rdata = stat_word(sync_f[1], frame_f[1], f2_f[1],
                                         f1_f[1], fld[1], pos[1]);
      OFS_IRQ_STAT: next_rdata = {30'h0, irq_st};
      OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
      OFS_CFG_A: next_rdata = {28'h0, cfg[0]};
      OFS_CFG_B: next_rdata = {28'h0, cfg[1]};
      OFS_VINT_A: next_rdata = vint[0];
      OFS_VINT_B: next_rdata = vint[1];
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Software configuration
  // ----------------------------------------
  // Byte enables respected on the wide vint words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg[0] <= '0;
      cfg[1] <= '0;
      vint[0] <= 32'h0000_0000;
      vint[1] <= 32'h0000_0000;
      irq_mask <= 2'b00;
    end else if (acc && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == OFS_VINT_A) begin
          vint[0][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
        if (wb_sel_i[b] && wb_adr_i == OFS_VINT_B) begin
          vint[1][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
      if (wb_sel_i[0] && wb_adr_i == OFS_CFG_A) begin
        cfg[0] <= wb_dat_i[3:0];
      end
      if (wb_sel_i[0] && wb_adr_i == OFS_CFG_B) begin
        cfg[1] <= wb_dat_i[3:0];
      end
      if (wb_sel_i[0] && wb_adr_i == OFS_IRQ_MASK) begin
        irq_mask <= wb_dat_i[1:0];
      end
    end
  end

  // ----------------------------------------
  // Position and field tracking
  // ----------------------------------------
  // Reserved mode code 2'b11 behaves as a counting mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos[0] <= 24'h00_0000;
      pos[1] <= 24'h00_0000;
      fld <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (comp[c]) begin
          pos[c] <= {cap_i[c].line_counter, cap_i[c].pixel_counter};
          fld[c] <= fld_now[c];
        end else begin
          pos[c] <= cap_i[c].sample_count;
          fld[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Frame sync
  // ----------------------------------------
  // Set beats clear when the vint line is programmed to 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_f <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!comp[c]) begin
          sync_f[c] <= 1'b0;
        end else if (sync_set[c]) begin
          sync_f[c] <= 1'b1;
        end else if (sync_clr[c]) begin
          sync_f[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Completion flags
  // ----------------------------------------
  // Hardware set wins over a same-cycle software clear, so no event is lost
  // Field flags only ever set in component modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_f <= 2'b00;
      f2_f <= 2'b00;
      f1_f <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        frame_f[c] <= (frame_f[c] & ~(wr_stat[c] & wb_dat_i[BIT_FRAME]))
                      | cap_i[c].frame_end;
        f2_f[c] <= (f2_f[c] & ~(wr_stat[c] & wb_dat_i[BIT_F2]))
                   | (comp[c] & cap_i[c].field_two_end);
        f1_f[c] <= (f1_f[c] & ~(wr_stat[c] & wb_dat_i[BIT_F1]))
                   | (comp[c] & cap_i[c].field_one_end);
      end
    end
  end

  // ----------------------------------------
  // Port interrupt
  // ----------------------------------------
  // Read clears; an arriving completion in the same cycle survives
  // Level output one cycle behind the status bits, so it never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= 2'b00;
      irq_o <= 1'b0;
    end else begin
      irq_st <= ((acc && !wb_we_i && wb_adr_i == OFS_IRQ_STAT) ? 2'b00 : irq_st)
                | {cap_i[1].frame_end, cap_i[0].frame_end};
      irq_o <= |(irq_st & irq_mask);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_stat_a;
    acc && !wb_we_i && wb_adr_i == OFS_STAT_A ##1 wb_ack_o;
  endsequence
  sequence s_clear_frame_a;
    wr_stat[0] && wb_dat_i[BIT_FRAME] && !cap_i[0].frame_end;
  endsequence
  sequence s_read_stat_b;
    acc && !wb_we_i && wb_adr_i == OFS_STAT_B ##1 wb_ack_o;
  endsequence
  sequence s_clear_frame_b;
    wr_stat[1] && wb_dat_i[BIT_FRAME] && !cap_i[1].frame_end;
  endsequence
  // A completion whose status bit is masked in one cycle later
  sequence s_done_masked_a;
    cap_i[0].frame_end ##1 (irq_st[0] && irq_mask[0]);
  endsequence

  a_line_field: assert property (comp[0] |=>
      pos[0][23:12] == $past(cap_i[0].line_counter))
    else $error("line field does not follow line counter");
  a_pixel_field: assert property (comp[1] |=>
      pos[1][11:0] == $past(cap_i[1].pixel_counter))
    else $error("pixel field does not follow pixel counter");
  a_sample_count: assert property (!comp[0] |=>
      pos[0] == $past(cap_i[0].sample_count))
    else $error("sample count not shown");
  a_frame_set: assert property (cap_i[1].frame_end |=> frame_f[1])
    else $error("frame flag not set");
  a_field_set: assert property (comp[0] && cap_i[0].field_two_end |=> f2_f[0])
    else $error("field two flag not set");
  a_flag_clear: assert property (s_clear_frame_a |=> !frame_f[0])
    else $error("write one did not clear frame flag");
  a_flag_keep: assert property (wr_stat[0] && !wb_dat_i[BIT_F1] && f1_f[0]
      |=> f1_f[0])
    else $error("write zero changed field one flag");
  a_sync_clear: assert property (sync_clr[0] && !sync_set[0] |=> !sync_f[0])
    else $error("sync flag not cleared at vertical line");
  a_sync_set: assert property (sync_set[1] |=> sync_f[1])
    else $error("sync flag not set at line one");
  a_field_idle: assert property (!comp[1] |=> !fld[1])
    else $error("active field set outside component mode");
  a_reserved_zero: assert property (s_read_stat_a |-> wb_dat_o[15:13] == 3'b000)
    else $error("reserved status bits read nonzero");
  a_irq_follow: assert property (cap_i[0].frame_end |=> irq_st[0])
    else $error("capture complete irq not raised");
  a_irq_masked: assert property (s_done_masked_a |=> irq_o)
    else $error("masked-in completion did not raise irq");

  // Other-channel mirrors of the checks above, plus field id, raw-mode and irq level checks
  a_frame_set_a: assert property (cap_i[0].frame_end |=> frame_f[0])
    else $error("channel A frame flag not set");
  a_field_one_set: assert property (comp[1] && cap_i[1].field_one_end |=> f1_f[1])
    else $error("field one flag not set");
  a_raw_fields: assert property (!comp[0] && !f1_f[0] && !f2_f[0]
      |=> !f1_f[0] && !f2_f[0])
    else $error("field flag set outside component mode");
  a_raw_sync: assert property (!comp[0] |=> !sync_f[0])
    else $error("sync flag set outside component mode");
  a_pixel_field_a: assert property (comp[0] |=>
      pos[0][11:0] == $past(cap_i[0].pixel_counter))
    else $error("channel A pixel field does not follow");
  a_line_field_b: assert property (comp[1] |=>
      pos[1][23:12] == $past(cap_i[1].line_counter))
    else $error("channel B line field does not follow");
  a_sample_count_b: assert property (!comp[1] |=>
      pos[1] == $past(cap_i[1].sample_count))
    else $error("channel B sample count not shown");
  a_field_by_sync: assert property (comp[0] && cfg[0].field_detect_select |=>
      fld[0] == $past(cap_i[0].fid_sync))
    else $error("active field ignores the sync-based id");
  a_field_by_code: assert property (comp[1] && !cfg[1].field_detect_select |=>
      fld[1] == $past(cap_i[1].fid_code))
    else $error("active field ignores the embedded id");
  a_clear_frame_b: assert property (s_clear_frame_b |=> !frame_f[1])
    else $error("write one did not clear channel B frame flag");
  a_reserved_b: assert property (s_read_stat_b |-> wb_dat_o[15:13] == 3'b000)
    else $error("channel B reserved bits read nonzero");
  a_frame_irq_b: assert property (cap_i[1].frame_end |=> irq_st[1])
    else $error("channel B capture complete irq not raised");
  a_irq_level: assert property (|(irq_st & irq_mask) |=> irq_o)
    else $error("irq low with an unmasked event pending");
  a_irq_quiet: assert property (!(|(irq_st & irq_mask)) |=> !irq_o)
    else $error("irq high with no unmasked event pending");

  // Checked through reset itself, so the default disable is overridden
  a_reset_zero: assert property (disable iff (1'b0) rst_i |=>
      sync_f == 2'b00 && frame_f == 2'b00 && f2_f == 2'b00 && f1_f == 2'b00
      && fld == 2'b00 && pos[0] == 24'h00_0000 && pos[1] == 24'h00_0000
      && irq_st == 2'b00 && !irq_o && !wb_ack_o)
    else $error("status not cleared by reset");
endmodule
`default_nettype wire
